// *** src/bttc_pkg.sv ***
/*
 bttc_pkg: constants and types for the breakpoint trace trigger control block.
 assumes: included first; every design file imports it.
*/
package bttc_pkg;
   localparam int          BP_NUM         = 15;
   localparam int          BP_PER_CTRL    = 9;
   localparam int          CODE_W         = 3;
   localparam int          CODES_W        = BP_NUM * CODE_W;
   localparam int          CTRL_CODES_W   = BP_PER_CTRL * CODE_W;
   localparam int          EXT_CODES_W    = CODES_W - CTRL_CODES_W;
   localparam int          IDX_W          = 4;
   localparam int          VPE_NUM        = 2;
   localparam int          MODE_W         = 5;
   localparam int          MORE_BIT       = 31;
   localparam int          RSV_BIT        = 30;
   localparam int          PCT_BIT        = 29;
   localparam int          EN_BIT         = 28;
   localparam int          RSV27_BIT      = 27;
   localparam logic [4:0]  CP0_REG_NUM    = 5'h17;
   localparam logic [2:0]  CP0_SEL_INSTR  = 3'h4;
   localparam logic [2:0]  CP0_SEL_DATA   = 3'h5;
   localparam logic [15:0] ADDR_INSTR_EXT = 16'h1ff8;
   localparam logic [15:0] ADDR_DATA_EXT  = 16'h2ff8;
   localparam logic [CODES_W-1:0] CODES_RST = '0;
   localparam logic [MODE_W-1:0]  MODE_RST  = '0;

   typedef enum logic [2:0] {
      BTTC_STOP_ALL      = 3'h0,
      BTTC_START_CORE    = 3'h1,
      BTTC_STOP_CORE     = 3'h2,
      BTTC_START_ALL     = 3'h3,
      BTTC_STOP_ALL_PD   = 3'h4,
      BTTC_START_CORE_PD = 3'h5,
      BTTC_RESERVED      = 3'h6,
      BTTC_START_ALL_PD  = 3'h7
   } bttc_action_e;
endpackage

// *** src/bttc_pick_if.sv ***
/*
 bttc_pick_if: the one trigger chosen on one side (instruction or data).
 assumes: driven by bttc_pick, read by the top in the same clock domain.
*/
`timescale 1ns/1ps
interface bttc_pick_if;
   import bttc_pkg::*;
   logic             valid;
   logic [IDX_W-1:0] idx;
   logic [2:0]       code;
   modport src (output valid, output idx, output code);
   modport dst (input valid, input idx, input code);
endinterface

// *** src/bttc_pick.sv ***
/*
 bttc_pick: lowest-numbered breakpoint among enabled matches, with its action code.
 assumes: matches already gated by the side's enable; purely combinational.
*/
`timescale 1ns/1ps
module bttc_pick
   import bttc_pkg::*;
(
   input  wire logic [bttc_pkg::BP_NUM-1:0]  i_match,
   input  wire logic [bttc_pkg::CODES_W-1:0] i_codes,
   bttc_pick_if.src                          o_pick
);
   function automatic logic [IDX_W-1:0] lowest(input logic [BP_NUM-1:0] m);
      logic [IDX_W-1:0] r;
      r = '0;
      for (int n = BP_NUM - 1; n >= 0; n--) begin
         if (m[n]) begin
            r = IDX_W'(n);
         end
      end
      return r;
   endfunction

   wire logic [IDX_W-1:0] first_idx = lowest(i_match);

   assign o_pick.valid = |i_match;
   assign o_pick.idx   = first_idx;
   // code n sits at 3n+2..3n across both words
   assign o_pick.code  = i_codes[first_idx*CODE_W +: CODE_W];
endmodule

// *** src/bttc_action_dec.sv ***
/*
 bttc_action_dec: turns a 3-bit action code into trace start/stop effects.
 assumes: code comes from a chosen trigger; reserved code has no effect.
*/
`timescale 1ns/1ps
module bttc_action_dec
   import bttc_pkg::*;
(
   input  wire logic [2:0] i_code,
   output logic            o_core_start,
   output logic            o_core_stop,
   output logic            o_cm_set,
   output logic            o_cm_clr,
   output logic            o_perf_dump
);
   wire bttc_action_e act = bttc_action_e'(i_code);
   wire logic is_rsv      = (act == BTTC_RESERVED);
   wire logic stop_all    = (act == BTTC_STOP_ALL) || (act == BTTC_STOP_ALL_PD);
   wire logic start_all   = (act == BTTC_START_ALL) || (act == BTTC_START_ALL_PD);
   wire logic start_core  = (act == BTTC_START_CORE) || (act == BTTC_START_CORE_PD);

   assign o_core_start = start_all || start_core;
   assign o_core_stop  = stop_all || (act == BTTC_STOP_CORE);
   assign o_cm_set     = start_all;
   assign o_cm_clr     = o_core_stop;
   // upper code bit doubles as the counter dump, except the reserved value
   assign o_perf_dump  = i_code[2] && !is_rsv;
endmodule

// *** src/bttc_top.sv ***
/*
 bttc_top: breakpoint trace control registers and breakpoint trigger selection.
 assumes: single core clock; coprocessor and debug-segment accesses and breakpoint
 matches arrive as same-clock one-cycle strobes; implemented/shared flags are static.
*/
// Operation
// - control register holds nine 3-bit action codes plus flag bits above
// - instruction extension register holds codes of the last six instruction breakpoints
// - data extension register holds codes of the last six data breakpoints
// - instruction control at coprocessor reg 23 sel 4, data at sel 5
// - chosen trigger starting coherence tracing sets coherence enable bit
// - chosen trigger stopping core tracing clears coherence enable bit
// - debug unit signals each breakpoint match; block takes it as trigger source
// - instruction and data triggers together: instruction wins, data discarded (a data match still gives the data bit 29 counter trigger pulse)
// - several triggers on one side: lowest-numbered breakpoint wins
// - trace kind follows third control mode, or software mode under software control
// - each control register has one enable blocking its side's triggers
// - no breakpoints implemented means registers and triggering are absent
// - unshared breakpoints duplicate registers per element; shared ones share them
// - instruction control bit 31 reads one when extension register is needed
// - bit 30 reads zero and ignores writes
// - bit 29 gives counter trigger pulse on instruction match while enabled
// - bit 28 instruction trigger enable; zero blocks instruction triggers
// - action codes decode to stop/start core or both, upper bit dumps counters
// - data bit 28 is data trigger enable; ignored without data breakpoints
// - codes of absent breakpoints read zero and ignore writes
`timescale 1ns/1ps
module bttc_top
   import bttc_pkg::*;
(
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_instr_bp_implemented,
   input  wire logic                         i_data_bp_implemented,
   input  wire logic                         i_instr_bp_shared,
   input  wire logic                         i_data_bp_shared,
   input  wire logic                         i_access_vpe,
   input  wire logic                         i_cp0_wr,
   input  wire logic [4:0]                   i_cp0_reg,
   input  wire logic [2:0]                   i_cp0_sel,
   input  wire logic [31:0]                  i_cp0_wdata,
   output logic      [31:0]                  o_cp0_rdata,
   input  wire logic                         i_drseg_wr,
   input  wire logic [15:0]                  i_drseg_addr,
   input  wire logic [31:0]                  i_drseg_wdata,
   output logic      [31:0]                  o_drseg_rdata,
   input  wire logic [bttc_pkg::BP_NUM-1:0]  i_instr_bp_match,
   input  wire logic [bttc_pkg::BP_NUM-1:0]  i_data_bp_match,
   input  wire logic                         i_match_vpe,
   input  wire logic [bttc_pkg::MODE_W-1:0]  i_trace_ctrl_third_mode,
   input  wire logic [bttc_pkg::MODE_W-1:0]  i_sw_trace_ctrl_second_mode,
   input  wire logic                         i_sw_trace_control,
   output logic                              o_trig_valid,
   output logic                              o_trig_data_side,
   output logic      [bttc_pkg::IDX_W-1:0]   o_trig_index,
   output logic      [2:0]                   o_trig_code,
   output logic                              o_core_trace_start,
   output logic                              o_core_trace_stop,
   output logic                              o_perf_dump,
   output logic                              o_perf_count_trigger,
   output logic                              o_coherence_trace_enable,
   output logic      [bttc_pkg::MODE_W-1:0]  o_trace_mode
);
   import bttc_pkg::*;

   // one storage set per element; element 0 serves every element when shared
   logic [VPE_NUM-1:0][CODES_W-1:0] icodes_reg;
   logic [VPE_NUM-1:0][CODES_W-1:0] dcodes_reg;
   logic [VPE_NUM-1:0]              ipct_reg;
   logic [VPE_NUM-1:0]              ien_reg;
   logic [VPE_NUM-1:0]              dpct_reg;
   logic [VPE_NUM-1:0]              den_reg;
   logic                            trig_valid_reg;
   logic                            trig_side_reg;
   logic [IDX_W-1:0]                trig_idx_reg;
   logic [2:0]                      trig_code_reg;
   logic                            core_start_reg;
   logic                            core_stop_reg;
   logic                            perf_dump_reg;
   logic                            pct_pulse_reg;
   logic                            cm_en_reg;
   logic                            cm_en_next;
   logic [MODE_W-1:0]               mode_reg;
   logic [31:0]                     cp0_rdata_reg;
   logic [31:0]                     drseg_rdata_reg;

   function automatic logic [31:0] ctrl_word(input logic more, input logic perf_count_trigger_en,
                                             input logic en,
                                             input logic [CODES_W-1:0] c);
      logic [31:0] w;
      w                       = '0;
      w[CTRL_CODES_W-1:0]     = c[CTRL_CODES_W-1:0];
      w[EN_BIT]               = en;
      w[PCT_BIT]              = perf_count_trigger_en;
      w[MORE_BIT]             = more;
      return w; // bits 30 and 27 stay zero
   endfunction

   function automatic logic [31:0] ext_word(input logic [CODES_W-1:0] c);
      return {{(32 - EXT_CODES_W){1'b0}}, c[CODES_W-1:CTRL_CODES_W]};
   endfunction

   // access decode
   wire logic cp0_hit    = (i_cp0_reg == CP0_REG_NUM);
   wire logic wr_ictrl   = i_cp0_wr && cp0_hit && (i_cp0_sel == CP0_SEL_INSTR);
   wire logic wr_dctrl   = i_cp0_wr && cp0_hit && (i_cp0_sel == CP0_SEL_DATA);
   wire logic wr_iext    = i_drseg_wr && (i_drseg_addr == ADDR_INSTR_EXT);
   wire logic wr_dext    = i_drseg_wr && (i_drseg_addr == ADDR_DATA_EXT);
   wire logic iacc_v     = i_instr_bp_shared ? 1'b0 : i_access_vpe;
   wire logic dacc_v     = i_data_bp_shared ? 1'b0 : i_access_vpe;
   wire logic imatch_v   = i_instr_bp_shared ? 1'b0 : i_match_vpe;
   wire logic dmatch_v   = i_data_bp_shared ? 1'b0 : i_match_vpe;
   // with no breakpoints nothing is writable, so the block reads as all zero
   wire logic i_more     = i_instr_bp_implemented && (BP_NUM > BP_PER_CTRL);
   wire logic d_more     = i_data_bp_implemented && (BP_NUM > BP_PER_CTRL);

   genvar v;
   generate
      for (v = 0; v < VPE_NUM; v++) begin : g_vpe
         always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst) begin
               icodes_reg[v] <= CODES_RST;
               ipct_reg[v]   <= 1'b0;
               ien_reg[v]    <= 1'b0;
            end else if (i_instr_bp_implemented && (iacc_v == 1'(v))) begin
               if (wr_ictrl) begin
                  icodes_reg[v][CTRL_CODES_W-1:0] <= i_cp0_wdata[CTRL_CODES_W-1:0];
                  ipct_reg[v] <= i_cp0_wdata[PCT_BIT];
                  ien_reg[v]  <= i_cp0_wdata[EN_BIT];
               end
               if (wr_iext) begin
                  icodes_reg[v][CODES_W-1:CTRL_CODES_W] <= i_drseg_wdata[EXT_CODES_W-1:0];
               end
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst) begin
               dcodes_reg[v] <= CODES_RST;
               dpct_reg[v]   <= 1'b0;
               den_reg[v]    <= 1'b0;
            end else if (i_data_bp_implemented && (dacc_v == 1'(v))) begin
               if (wr_dctrl) begin
                  dcodes_reg[v][CTRL_CODES_W-1:0] <= i_cp0_wdata[CTRL_CODES_W-1:0];
                  dpct_reg[v] <= i_cp0_wdata[PCT_BIT];
                  den_reg[v]  <= i_cp0_wdata[EN_BIT];
               end
               if (wr_dext) begin
                  dcodes_reg[v][CODES_W-1:CTRL_CODES_W] <= i_drseg_wdata[EXT_CODES_W-1:0];
               end
            end
         end
      end
   endgenerate

   // read path, one cycle of latency; unmapped reads return zero
   wire logic [31:0] cp0_rd_next =
      !cp0_hit ? 32'h0 :
      (i_cp0_sel == CP0_SEL_INSTR) ?
         ctrl_word(i_more, ipct_reg[iacc_v], ien_reg[iacc_v], icodes_reg[iacc_v]) :
      (i_cp0_sel == CP0_SEL_DATA) ?
         ctrl_word(d_more, dpct_reg[dacc_v], den_reg[dacc_v], dcodes_reg[dacc_v]) :
      32'h0;
   wire logic [31:0] drseg_rd_next =
      (i_drseg_addr == ADDR_INSTR_EXT) ? ext_word(icodes_reg[iacc_v]) :
      (i_drseg_addr == ADDR_DATA_EXT)  ? ext_word(dcodes_reg[dacc_v]) :
      32'h0;

   // enables gate the matches before any choice is made
   wire logic                ien_sel   = ien_reg[imatch_v] && i_instr_bp_implemented;
   wire logic                den_sel   = den_reg[dmatch_v] && i_data_bp_implemented;
   wire logic [BP_NUM-1:0]   imatch_en = ien_sel ? i_instr_bp_match : '0;
   wire logic [BP_NUM-1:0]   dmatch_en = den_sel ? i_data_bp_match : '0;
   wire logic                pct_next  = (|imatch_en && ipct_reg[imatch_v]) ||
                                         (|dmatch_en && dpct_reg[dmatch_v]);

   bttc_pick_if ipick ();
   bttc_pick_if dpick ();

   bttc_pick u_ipick (
      .i_match (imatch_en),
      .i_codes (icodes_reg[imatch_v]),
      .o_pick  (ipick.src)
   );
   bttc_pick u_dpick (
      .i_match (dmatch_en),
      .i_codes (dcodes_reg[dmatch_v]),
      .o_pick  (dpick.src)
   );

   // data side only counts when the instruction side is quiet
   wire logic             sel_valid = ipick.valid || dpick.valid;
   wire logic             sel_data  = !ipick.valid;
   wire logic [IDX_W-1:0] sel_idx   = ipick.valid ? ipick.idx : dpick.idx;
   wire logic [2:0]       sel_code  = ipick.valid ? ipick.code : dpick.code;
   logic dec_start;
   logic dec_stop;
   logic dec_cm_set;
   logic dec_cm_clr;
   logic dec_dump;

   bttc_action_dec u_dec (
      .i_code       (sel_code),
      .o_core_start (dec_start),
      .o_core_stop  (dec_stop),
      .o_cm_set     (dec_cm_set),
      .o_cm_clr     (dec_cm_clr),
      .o_perf_dump  (dec_dump)
   );

   assign cm_en_next = (sel_valid && dec_cm_set) ? 1'b1 :
                       (sel_valid && dec_cm_clr) ? 1'b0 :
                       cm_en_reg;
   wire logic [MODE_W-1:0] mode_next = i_sw_trace_control ? i_sw_trace_ctrl_second_mode
                                                          : i_trace_ctrl_third_mode;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         trig_valid_reg  <= 1'b0;
         trig_side_reg   <= 1'b0;
         trig_idx_reg    <= '0;
         trig_code_reg   <= 3'h0;
         core_start_reg  <= 1'b0;
         core_stop_reg   <= 1'b0;
         perf_dump_reg   <= 1'b0;
         pct_pulse_reg   <= 1'b0;
         cm_en_reg       <= 1'b0;
         mode_reg        <= MODE_RST;
         cp0_rdata_reg   <= 32'h0;
         drseg_rdata_reg <= 32'h0;
      end else begin
         trig_valid_reg  <= sel_valid;
         trig_side_reg   <= sel_valid && sel_data;
         trig_idx_reg    <= sel_valid ? sel_idx : '0;
         trig_code_reg   <= sel_valid ? sel_code : 3'h0;
         core_start_reg  <= sel_valid && dec_start;
         core_stop_reg   <= sel_valid && dec_stop;
         perf_dump_reg   <= sel_valid && dec_dump;
         pct_pulse_reg   <= pct_next;
         cm_en_reg       <= cm_en_next;
         mode_reg        <= mode_next;
         cp0_rdata_reg   <= cp0_rd_next;
         drseg_rdata_reg <= drseg_rd_next;
      end
   end

   assign o_trig_valid             = trig_valid_reg;
   assign o_trig_data_side         = trig_side_reg;
   assign o_trig_index             = trig_idx_reg;
   assign o_trig_code              = trig_code_reg;
   assign o_core_trace_start       = core_start_reg;
   assign o_core_trace_stop        = core_stop_reg;
   assign o_perf_dump              = perf_dump_reg;
   assign o_perf_count_trigger     = pct_pulse_reg;
   assign o_coherence_trace_enable = cm_en_reg;
   assign o_trace_mode             = mode_reg;
   assign o_cp0_rdata              = cp0_rdata_reg;
   assign o_drseg_rdata            = drseg_rdata_reg;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   instr_wins_a: assert property (|imatch_en |=> o_trig_valid && !o_trig_data_side)
      else $error("instruction trigger not chosen");
   data_only_a: assert property (!(|imatch_en) && |dmatch_en |=> o_trig_data_side)
      else $error("data trigger lost");
   lowest_idx_a: assert property (imatch_en[0] |=> o_trig_index == '0)
      else $error("lowest breakpoint not chosen");
   enable_block_a: assert property (!ien_sel && !den_sel |=> !o_trig_valid)
      else $error("trigger passed a cleared enable");
   absent_off_a: assert property (!i_instr_bp_implemented && !i_data_bp_implemented
                                  |=> !o_trig_valid)
      else $error("trigger with no breakpoints");
   cm_set_a: assert property (o_trig_valid && o_trig_code[1:0] == 2'h3
                              |-> o_coherence_trace_enable)
      else $error("coherence enable not set");
   cm_clr_a: assert property (o_trig_valid && (o_trig_code[1:0] == 2'h0 ||
                              o_trig_code == 3'h2) |-> !o_coherence_trace_enable)
      else $error("coherence enable not cleared");
   // the release edge still loads reset values, so no attempt starts there
   mode_pick_a: assert property (!i_sys_rst |=> o_trace_mode == ($past(i_sw_trace_control) ?
                                 $past(i_sw_trace_ctrl_second_mode) :
                                 $past(i_trace_ctrl_third_mode)))
      else $error("trace mode from wrong source");
   pct_pulse_a: assert property (|imatch_en && ipct_reg[imatch_v]
                                 |=> o_perf_count_trigger)
      else $error("counter trigger missing");
   rsv_zero_a: assert property (!o_cp0_rdata[RSV_BIT] && !o_cp0_rdata[RSV27_BIT])
      else $error("reserved bit reads one");
   more_bit_a: assert property (!i_sys_rst && cp0_hit && i_cp0_sel == CP0_SEL_INSTR
                                |=> o_cp0_rdata[MORE_BIT] == $past(i_more))
      else $error("extension present bit wrong");

   cover_instr_c: cover property (|imatch_en ##1 o_trig_valid);
   cover_data_c: cover property (|dmatch_en && !(|imatch_en) ##1 o_trig_data_side);
   cover_both_c: cover property (|imatch_en && |dmatch_en);
   cover_cm_c: cover property (!o_coherence_trace_enable ##1 o_coherence_trace_enable);
endmodule

// *** testbench/bttc_match_model.sv ***
/*
 bttc_match_model: breakpoint matching side of the debug unit, driven by bench commands.
 assumes: commands change by nonblocking assignment at the rising core clock edge.
*/
`timescale 1ns/1ps
module bttc_match_model
   import bttc_pkg::*;
(
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_fire,
   input  wire logic [bttc_pkg::BP_NUM-1:0] i_instr_hits,
   input  wire logic [bttc_pkg::BP_NUM-1:0] i_data_hits,
   input  wire logic                        i_vpe,
   output logic      [bttc_pkg::BP_NUM-1:0] o_instr_bp_match,
   output logic      [bttc_pkg::BP_NUM-1:0] o_data_bp_match,
   output logic                             o_match_vpe
);
   // one-cycle pulses; idle element line toggles so a stale value never looks valid
   always_ff @(posedge i_sys_clk) begin
      o_instr_bp_match <= i_fire ? i_instr_hits : '0;
      o_data_bp_match  <= i_fire ? i_data_hits : '0;
      o_match_vpe      <= i_fire ? i_vpe : ~o_match_vpe;
   end
endmodule

// *** testbench/bttc_tb_top.sv ***
/*
 bttc_tb_top: self-checking bench for bttc_top with a breakpoint matching model.
 assumes: registers reached over coprocessor and debug-segment ports, single 40 MHz clock.
*/
`timescale 1ns/1ps
module bttc_tb_top;
   import bttc_pkg::*;
   logic        clk = 0, rst = 1, iimp = 1, dimp = 1, avpe = 0, cwr = 0, dwr = 0;
   logic        sw = 0, fire = 0, fvpe = 0, mvpe, tv, ts, cs, cp, pd, perf_count_trigger_en, cm, cme = 0;
   logic        ishr = 0, dshr = 0;
   logic [4:0]  creg = 0, tmode = 0, smode = 0, tm;
   logic [2:0]  csel = 0, tc;
   logic [3:0]  ti;
   logic [15:0] daddr = 0;
   logic [31:0] cwd = 0, dwd = 0, crd, drd, rnd;
   logic [14:0] ih = 0, dh = 0, im, dm;
   logic [31:0] sh [5][2] = '{default: '0};
   int          seed = 32'h71c4, bad_count = 0, compares = 0;

   always #12.5 clk = ~clk;

   bttc_match_model u_bttc_match_model (.i_sys_clk(clk), .i_fire(fire), .i_instr_hits(ih),
      .i_data_hits(dh), .i_vpe(fvpe), .o_instr_bp_match(im), .o_data_bp_match(dm),
      .o_match_vpe(mvpe));
   // shared flags low until the last phase: per-element storage is the harder case
   bttc_top u_bttc_top (.i_sys_clk(clk), .i_sys_rst(rst), .i_instr_bp_implemented(iimp),
      .i_data_bp_implemented(dimp), .i_instr_bp_shared(ishr), .i_data_bp_shared(dshr),
      .i_access_vpe(avpe), .i_cp0_wr(cwr), .i_cp0_reg(creg), .i_cp0_sel(csel),
      .i_cp0_wdata(cwd), .o_cp0_rdata(crd), .i_drseg_wr(dwr), .i_drseg_addr(daddr),
      .i_drseg_wdata(dwd), .o_drseg_rdata(drd), .i_instr_bp_match(im),
      .i_data_bp_match(dm), .i_match_vpe(mvpe), .i_trace_ctrl_third_mode(tmode),
      .i_sw_trace_ctrl_second_mode(smode), .i_sw_trace_control(sw), .o_trig_valid(tv),
      .o_trig_data_side(ts), .o_trig_index(ti), .o_trig_code(tc), .o_core_trace_start(cs),
      .o_core_trace_stop(cp), .o_perf_dump(pd), .o_perf_count_trigger(perf_count_trigger_en),
      .o_coherence_trace_enable(cm), .o_trace_mode(tm));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task final_report;
      if (bad_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [3:0] low(input logic [14:0] m);
      low = 4'h0;
      for (int k = 14; k >= 0; k--) if (m[k]) low = k[3:0];
   endfunction

   // r: 0 instr ctrl, 1 data ctrl, 2 instr ext, 3 data ext, 4 unmapped
   task automatic put(input int r, input logic v);
      avpe  <= v;
      creg  <= CP0_REG_NUM;
      csel  <= (r == 1) ? CP0_SEL_DATA : CP0_SEL_INSTR;
      daddr <= (r == 2) ? ADDR_INSTR_EXT : (r == 3) ? ADDR_DATA_EXT : 16'h3000;
   endtask

   task automatic wr(input int r, input logic v, input logic [31:0] d);
      @(posedge clk);
      put(r, v);
      if (r < 2) cwr <= 1'b1;
      else dwr <= 1'b1;
      cwd <= d;
      dwd <= d;
      @(posedge clk);
      cwr <= 1'b0;
      dwr <= 1'b0;
      if (r < 4 && ((r % 2) ? dimp : iimp))
         sh[r][v & ~((r % 2) ? dshr : ishr)] = d & ((r < 2) ? 32'h37ff_ffff : 32'h0003_ffff);
   endtask

   task automatic rd(input int r, input logic v);
      logic e;
      @(posedge clk);
      put(r, v);
      @(posedge clk);
      #1;
      e = v & ~((r % 2) ? dshr : ishr);
      if (r < 2) chk(crd, sh[r][e] | {(r ? dimp : iimp), 31'h0});
      else chk(drd, sh[r][e]);
   endtask

   task automatic trig(input logic v, input logic [14:0] i, input logic [14:0] d);
      logic [14:0] ei, ed;
      logic [44:0] cd;
      logic [3:0]  x;
      logic [2:0]  c;
      logic        s, vl, iv, dv;
      rnd = $random(seed);
      @(posedge clk);
      fire  <= 1'b1;
      ih    <= i;
      dh    <= d;
      fvpe  <= v;
      sw    <= rnd[0];
      tmode <= rnd[5:1];
      smode <= rnd[10:6];
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
      #1;
      iv = v & ~ishr;
      dv = v & ~dshr;
      ei = i & {15{sh[0][iv][EN_BIT] & iimp}};
      ed = d & {15{sh[1][dv][EN_BIT] & dimp}};
      vl = |{ei, ed};
      s  = ~|ei & |ed;
      cd = s ? {sh[3][dv][17:0], sh[1][dv][26:0]} : {sh[2][iv][17:0], sh[0][iv][26:0]};
      x  = low(s ? ed : ei);
      c  = vl ? cd[3*x+:3] : 3'h0;
      chk({tv, ts, ti, tc}, {vl, s, x, c});
      chk({cs, cp, pd}, {vl & c[0], vl & ~c[0] & (c != 3'h6), vl & c[2] & (c != 3'h6)});
      if (vl && c[1:0] == 2'b11) cme = 1'b1;
      else if (vl && !c[0] && c != 3'h6) cme = 1'b0;
      chk(cm, cme);
      if (!(|ei && |ed)) chk(perf_count_trigger_en, (|ei & sh[0][iv][PCT_BIT]) | (|ed & sh[1][dv][PCT_BIT]));
      chk(tm, rnd[0] ? rnd[10:6] : rnd[5:1]);
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      final_report;
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 5; r++) for (int v = 0; v < 2; v++) rd(r, v[0]);
      wr(0, 0, '1);
      rd(0, 0);
      wr(3, 1, '1);
      rd(3, 1);
      wr(4, 0, '1);
      rd(4, 0);
      rd(0, 1);
      // awkward cases: mixed sides, several per side, extension indices, disabled side
      wr(0, 0, 32'h3000_0018);
      wr(1, 0, 32'h1000_0001);
      trig(0, 15'h0006, 15'h0001);
      trig(0, 15'h0000, 15'h0003);
      wr(2, 0, 32'h0000_0e00);
      trig(0, 15'h5000, 15'h0000);
      trig(0, 15'h0000, 15'h0000);
      wr(0, 0, 32'h0000_0018);
      trig(0, 15'h0002, 15'h0001);
      for (int n = 0; n < 300; n++) begin
         rnd = $random(seed);
         wr(rnd[1:0], rnd[2], $random(seed) | {3'h0, rnd[3], 28'h0});
         if (rnd[4]) rd(rnd[1:0], rnd[2]);
         rnd = $random(seed);
         trig(rnd[30], rnd[14:0] & $random(seed), rnd[29:15] & $random(seed));
      end
      // absent data breakpoints and shared storage: element 1 lands in element 0
      @(posedge clk);
      rst  <= 1'b1;
      dimp <= 1'b0;
      ishr <= 1'b1;
      dshr <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      sh  = '{default: '0};
      cme = 1'b0;
      wr(1, 0, '1);
      rd(1, 0);
      trig(0, 15'h0000, 15'h0001);
      wr(0, 1, 32'h3000_0008);
      rd(0, 0);
      trig(1, 15'h0002, 15'h0000);
      final_report;
   end
endmodule
